// file: shared/dcef_pkg.sv
// Constants and types for the DMA channel event flag block.
// Assumes a single clock domain and a 32-bit AXI4-Lite register bus.
package dcef_pkg;
   localparam int NCH = 4;
   localparam int NIRQ = 64;
   localparam int SEL_W = 6;
   localparam int SIZE_W = 16;
   localparam int ADDR_W = 8;
   localparam int NEV = 5;

   // Event bit positions in channel_event_flags
   localparam int EV_ADDR_ERR = 0;
   localparam int EV_ABORT = 1;
   localparam int EV_CELL = 2;
   localparam int EV_BLOCK = 3;
   localparam int EV_HALF = 4;

   // Per channel register offsets, channel n at n * CH_STRIDE
   localparam logic [ADDR_W-1:0] CH_STRIDE = 8'h20;
   localparam logic [4:0] OFF_FLAGS = 5'h00;
   localparam logic [4:0] OFF_MASK = 5'h04;
   localparam logic [4:0] OFF_CTRL = 5'h08;
   localparam logic [4:0] OFF_SRC_SIZE = 5'h0c;
   localparam logic [4:0] OFF_DST_SIZE = 5'h10;
   localparam logic [4:0] OFF_CELL_SIZE = 5'h14;
   localparam logic [ADDR_W-1:0] OFF_SUMMARY = 8'h80;

   // Control register fields
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_ABORT_EN = 1;
   localparam int CTRL_SEL_LSB = 8;

   localparam logic [NEV-1:0] FLAGS_RESET = 5'h00;
   localparam logic [NEV-1:0] MASK_RESET = 5'h00;
   localparam logic [SIZE_W-1:0] SIZE_RESET = 16'h0000;
   localparam logic [SEL_W-1:0] SEL_RESET = 6'h00;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WS_COLLECT = 2'b01,
      WS_RESP = 2'b10
   } dcef_wr_e;
endpackage

// file: hw/dcef_chan.sv
// One DMA channel's event detection: cell and block byte counters,
// half-full compare, abort trigger select and address error capture.
// Assumes the transfer engine reports steps of one byte each.
`timescale 1ns/100ps
module dcef_chan (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic enable,
   input wire logic abort_en,
   input wire logic [dcef_pkg::SEL_W-1:0] abort_irq_select,
   input wire logic [dcef_pkg::NIRQ-1:0] periph_irq,
   input wire logic [dcef_pkg::SIZE_W-1:0] source_size,
   input wire logic [dcef_pkg::SIZE_W-1:0] dest_size,
   input wire logic [dcef_pkg::SIZE_W-1:0] cell_size,
   input wire logic [dcef_pkg::SIZE_W-1:0] dest_pointer,
   input wire logic xfer_step,
   input wire logic pattern_match,
   input wire logic src_addr_bad,
   input wire logic dst_addr_bad,
   output logic [dcef_pkg::NEV-1:0] event_pulse,
   output logic abort_req
);
   logic irq_prev;
   logic [dcef_pkg::SIZE_W-1:0] cell_cnt;
   logic [dcef_pkg::SIZE_W-1:0] block_cnt;
   logic [dcef_pkg::SIZE_W-1:0] block_len;
   logic sel_irq;
   logic abort_hit;
   logic cell_end;
   logic block_end;
   logic half_hit;

   assign block_len = (source_size > dest_size) ? source_size : dest_size;
   assign sel_irq = periph_irq[abort_irq_select];
   // Rising edge only, so a held interrupt does not abort again
   assign abort_hit = enable && abort_en && sel_irq && !irq_prev;
   assign cell_end = enable && xfer_step && cell_size != '0 &&
                     ({1'b0, cell_cnt} + 17'h00001) == {1'b0, cell_size};
   assign block_end = enable && ((xfer_step && block_len != '0 &&
                     ({1'b0, block_cnt} + 17'h00001) == {1'b0, block_len}) || pattern_match);
   assign half_hit = enable && xfer_step && dest_size != '0 &&
                     dest_pointer == (dest_size >> 1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_prev <= 1'b0;
      end else if (ce) begin
         irq_prev <= sel_irq;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cell_cnt <= '0;
      end else if (ce) begin
         if (!enable || cell_end || block_end || abort_hit) begin
            cell_cnt <= '0;
         end else if (xfer_step) begin
            cell_cnt <= cell_cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         block_cnt <= '0;
      end else if (ce) begin
         if (!enable || block_end || abort_hit) begin
            block_cnt <= '0;
         end else if (xfer_step) begin
            block_cnt <= block_cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         event_pulse <= '0;
         abort_req <= 1'b0;
      end else if (ce) begin
         event_pulse[dcef_pkg::EV_HALF] <= half_hit;
         event_pulse[dcef_pkg::EV_BLOCK] <= block_end;
         event_pulse[dcef_pkg::EV_CELL] <= cell_end;
         event_pulse[dcef_pkg::EV_ABORT] <= abort_hit;
         event_pulse[dcef_pkg::EV_ADDR_ERR] <= src_addr_bad || dst_addr_bad;
         abort_req <= abort_hit;
      end
   end
endmodule

// file: hw/dcef_top.sv
// DMA channel event flags: four channels of sticky event flags with masks,
// channel configuration and one interrupt, behind an AXI4-Lite slave.
// Assumes the transfer engine drives pointers, steps and error strobes
// synchronous to aclk, and stops a channel when its abort output pulses.
`timescale 1ns/100ps
module dcef_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [dcef_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [dcef_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [dcef_pkg::NIRQ-1:0] periph_irq,
   input wire logic [dcef_pkg::NCH-1:0][dcef_pkg::SIZE_W-1:0] dest_pointer,
   input wire logic [dcef_pkg::NCH-1:0] xfer_step,
   input wire logic [dcef_pkg::NCH-1:0] pattern_match,
   input wire logic [dcef_pkg::NCH-1:0] src_addr_bad,
   input wire logic [dcef_pkg::NCH-1:0] dst_addr_bad,
   output logic [dcef_pkg::NCH-1:0] chan_enable,
   output logic [dcef_pkg::NCH-1:0] chan_abort,
   output logic irq
);
   localparam int NCH = dcef_pkg::NCH;
   localparam int NEV = dcef_pkg::NEV;
   localparam int SW = dcef_pkg::SIZE_W;

   // Write address and data are caught separately, in either order
   dcef_pkg::dcef_wr_e wr_state;
   logic aw_full;
   logic w_full;
   logic [dcef_pkg::ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic wr_hit;
   logic rd_fire;
   logic rd_hit;
   logic [31:0] rd_word;
   logic [dcef_pkg::ADDR_W-1:0] rd_addr;
   logic [NCH-1:0] wr_chan;
   logic [NCH-1:0] rd_chan;

   logic [NCH-1:0][NEV-1:0] channel_event_flags;
   logic [NCH-1:0][NEV-1:0] event_mask;
   logic [NCH-1:0] abort_en;
   logic [NCH-1:0][dcef_pkg::SEL_W-1:0] abort_irq_select;
   logic [NCH-1:0][SW-1:0] source_size;
   logic [NCH-1:0][SW-1:0] dest_size;
   logic [NCH-1:0][SW-1:0] cell_size;
   logic [NCH-1:0][NEV-1:0] event_pulse;
   logic [NCH-1:0][NEV-1:0] flag_clear;

   // Register selected by an address: channel in bits 6:5, offset in 4:0
   function automatic logic [NCH-1:0] chan_sel(input logic [dcef_pkg::ADDR_W-1:0] a);
      logic [NCH-1:0] s;
      s = '0;
      if (!a[7]) begin
         s[a[6:5]] = 1'b1;
      end
      return s;
   endfunction

   function automatic logic reg_known(input logic [dcef_pkg::ADDR_W-1:0] a);
      logic k;
      k = 1'b0;
      if (a == dcef_pkg::OFF_SUMMARY) begin
         k = 1'b1;
      end else if (!a[7]) begin
         case (a[4:0])
            dcef_pkg::OFF_FLAGS,
            dcef_pkg::OFF_MASK,
            dcef_pkg::OFF_CTRL,
            dcef_pkg::OFF_SRC_SIZE,
            dcef_pkg::OFF_DST_SIZE,
            dcef_pkg::OFF_CELL_SIZE: k = 1'b1;
            default: k = 1'b0;
         endcase
      end
      return k;
   endfunction

   // Byte lane merge of a write into an old value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   assign s_axi_awready = !aw_full && wr_state == dcef_pkg::WS_COLLECT;
   assign s_axi_wready = !w_full && wr_state == dcef_pkg::WS_COLLECT;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire = ce && wr_state == dcef_pkg::WS_COLLECT && aw_full && w_full;
   assign wr_hit = reg_known(aw_addr) && aw_addr != dcef_pkg::OFF_SUMMARY;
   assign rd_fire = ce && s_axi_arvalid && s_axi_arready;
   // Low address bits ignored on reads as on writes
   assign rd_addr = {s_axi_araddr[dcef_pkg::ADDR_W-1:2], 2'b00};
   assign rd_hit = reg_known(rd_addr);
   assign wr_chan = chan_sel(aw_addr);
   assign rd_chan = chan_sel(rd_addr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr <= '0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= {s_axi_awaddr[dcef_pkg::ADDR_W-1:2], 2'b00};
         end else if (wr_fire) begin
            aw_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (ce) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state <= dcef_pkg::WS_COLLECT;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= dcef_pkg::RESP_OKAY;
      end else if (ce) begin
         case (wr_state)
            dcef_pkg::WS_COLLECT: begin
               if (wr_fire) begin
                  wr_state <= dcef_pkg::WS_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_hit ? dcef_pkg::RESP_OKAY : dcef_pkg::RESP_SLVERR;
               end
            end
            dcef_pkg::WS_RESP: begin
               if (s_axi_bready) begin
                  wr_state <= dcef_pkg::WS_COLLECT;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               wr_state <= dcef_pkg::WS_COLLECT;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // Configuration writes; the channel enable also drops on an abort
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         event_mask <= '0;
         chan_enable <= '0;
         abort_en <= '0;
         abort_irq_select <= '0;
         source_size <= '0;
         dest_size <= '0;
         cell_size <= '0;
      end else if (ce) begin
         for (int c = 0; c < NCH; c++) begin
            if (wr_fire && wr_hit && wr_chan[c]) begin
               case (aw_addr[4:0])
                  dcef_pkg::OFF_MASK: begin
                     event_mask[c] <= NEV'(merge({27'h0, event_mask[c]}, w_data, w_strb));
                  end
                  dcef_pkg::OFF_CTRL: begin
                     if (w_strb[0]) begin
                        chan_enable[c] <= w_data[dcef_pkg::CTRL_ENABLE];
                        abort_en[c] <= w_data[dcef_pkg::CTRL_ABORT_EN];
                     end
                     if (w_strb[1]) begin
                        abort_irq_select[c] <= w_data[dcef_pkg::CTRL_SEL_LSB +: dcef_pkg::SEL_W];
                     end
                  end
                  dcef_pkg::OFF_SRC_SIZE: begin
                     source_size[c] <= SW'(merge({16'h0, source_size[c]}, w_data, w_strb));
                  end
                  dcef_pkg::OFF_DST_SIZE: begin
                     dest_size[c] <= SW'(merge({16'h0, dest_size[c]}, w_data, w_strb));
                  end
                  dcef_pkg::OFF_CELL_SIZE: begin
                     cell_size[c] <= SW'(merge({16'h0, cell_size[c]}, w_data, w_strb));
                  end
                  default: begin
                  end
               endcase
            end
            // Abort wins over a software enable in the same cycle
            if (chan_abort[c]) begin
               chan_enable[c] <= 1'b0;
            end
         end
      end
   end

   // A read of a channel's flag register clears what it returned
   always_comb begin
      flag_clear = '0;
      for (int c = 0; c < NCH; c++) begin
         if (rd_fire && rd_hit && rd_chan[c] &&
             rd_addr[4:0] == dcef_pkg::OFF_FLAGS) begin
            flag_clear[c] = channel_event_flags[c];
         end
      end
   end

   // Set wins over the read clear so no event is lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         channel_event_flags <= '0;
      end else if (ce) begin
         for (int c = 0; c < NCH; c++) begin
            channel_event_flags[c] <= (channel_event_flags[c] & ~flag_clear[c]) | event_pulse[c];
         end
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      if (rd_addr == dcef_pkg::OFF_SUMMARY) begin
         for (int c = 0; c < NCH; c++) begin
            rd_word[c] = |channel_event_flags[c];
            rd_word[8 + c] = chan_enable[c];
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (rd_chan[c]) begin
               case (rd_addr[4:0])
                  dcef_pkg::OFF_FLAGS: rd_word[NEV-1:0] = channel_event_flags[c];
                  dcef_pkg::OFF_MASK: rd_word[NEV-1:0] = event_mask[c];
                  dcef_pkg::OFF_CTRL: begin
                     rd_word[dcef_pkg::CTRL_ENABLE] = chan_enable[c];
                     rd_word[dcef_pkg::CTRL_ABORT_EN] = abort_en[c];
                     rd_word[dcef_pkg::CTRL_SEL_LSB +: dcef_pkg::SEL_W] = abort_irq_select[c];
                  end
                  dcef_pkg::OFF_SRC_SIZE: rd_word[SW-1:0] = source_size[c];
                  dcef_pkg::OFF_DST_SIZE: rd_word[SW-1:0] = dest_size[c];
                  dcef_pkg::OFF_CELL_SIZE: rd_word[SW-1:0] = cell_size[c];
                  default: rd_word = 32'h0000_0000;
               endcase
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= dcef_pkg::RESP_OKAY;
      end else if (ce) begin
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_hit ? rd_word : 32'h0000_0000;
            s_axi_rresp <= rd_hit ? dcef_pkg::RESP_OKAY : dcef_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Same event logic per channel
   for (genvar g = 0; g < NCH; g++) begin : g_chan
      dcef_chan u_chan (
         .aclk(aclk),
         .aresetn(aresetn),
         .ce(ce),
         .enable(chan_enable[g]),
         .abort_en(abort_en[g]),
         .abort_irq_select(abort_irq_select[g]),
         .periph_irq(periph_irq),
         .source_size(source_size[g]),
         .dest_size(dest_size[g]),
         .cell_size(cell_size[g]),
         .dest_pointer(dest_pointer[g]),
         .xfer_step(xfer_step[g]),
         .pattern_match(pattern_match[g]),
         .src_addr_bad(src_addr_bad[g]),
         .dst_addr_bad(dst_addr_bad[g]),
         .event_pulse(event_pulse[g]),
         .abort_req(chan_abort[g])
      );
   end

   // Level interrupt, combinational from flags and masks
   always_comb begin
      irq = 1'b0;
      for (int c = 0; c < NCH; c++) begin
         irq = irq | (|(channel_event_flags[c] & event_mask[c]));
      end
   end
endmodule

// file: tb/dcef_props.sv
// Checker for the event flag block: bus answers, refusals, abort pulses.
// Bound to dcef_top and sees its ports only.
`timescale 1ns/100ps
module dcef_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] chan_enable,
   input wire logic [3:0] chan_abort,
   input wire logic irq
);
   logic unm;
   assign unm = s_axi_araddr[7] ? (s_axi_araddr[6:2] != 5'h00) : (s_axi_araddr[4:2] > 3'h5);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   for (genvar i = 0; i < 4; i++) begin : g_ch
      a_abort_single: assert property (chan_abort[i] && ce |=> !chan_abort[i])
         else $error("abort pulse longer than one cycle");
      a_abort_stops: assert property (chan_abort[i] && ce |=> !chan_enable[i])
         else $error("channel still enabled after abort");
      a_abort_cause: assert property ($rose(chan_abort[i]) |-> $past(chan_enable[i]))
         else $error("abort on a disabled channel");
   end
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
      else $error("read answer late");
   a_rd_hold: assert property (s_axi_rvalid && !(s_axi_rready && ce)
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer moved");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce ##1 ce
      |=> s_axi_bvalid) else $error("write answer late");
   a_wr_hold: assert property (s_axi_bvalid && !(s_axi_bready && ce) |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer moved");
   a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
   a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && ce && unm
      |=> s_axi_rresp == dcef_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
   c_abort: cover property (chan_abort[0]);
   c_irq: cover property ($rose(irq));
   c_slverr: cover property (s_axi_rvalid && s_axi_rresp == dcef_pkg::RESP_SLVERR);
endmodule
bind dcef_top dcef_props u_props (.*);

// file: tb/dcef_eng_model.sv
// Transfer engine stand-in: moves bytes one at a time on one channel.
// Assumes the bench sets sel and count while pulsing go.
`timescale 1ns/100ps
module dcef_eng_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic go,
   input wire logic [1:0] sel,
   input wire logic [15:0] count,
   input wire logic slow,
   input wire logic [3:0] chan_enable,
   input wire logic [3:0] chan_abort,
   output logic busy,
   output logic [3:0] xfer_step,
   output logic [3:0][15:0] dest_pointer
);
   logic [15:0] left;
   assign busy = go || left != 16'h0;
   always_ff @(posedge aclk) begin
      xfer_step <= 4'h0;
      if (!aresetn) begin
         left <= 16'h0;
         dest_pointer <= '0;
      end else begin
         for (int c = 0; c < 4; c++) begin
            if (!chan_enable[c]) dest_pointer[c] <= 16'h0;
         end
         if (go) begin
            left <= count;
         end else if (left != 16'h0 && (chan_abort[sel] || !chan_enable[sel])) begin
            left <= 16'h0;
         end else if (left != 16'h0 && !(slow && $urandom_range(1, 0) == 0)) begin
            // Slow mode stalls at random, like a busy bus
            left <= left - 16'h1;
            xfer_step[sel] <= 1'b1;
            dest_pointer[sel] <= dest_pointer[sel] + 16'h1;
         end
      end
   end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the DMA channel event flag block.
// Assumes the engine stand-in drives steps; the bench drives bus and events.
`timescale 1ns/100ps
module tb_top;
   localparam logic [1:0] OK = dcef_pkg::RESP_OKAY;
   localparam logic [1:0] ER = dcef_pkg::RESP_SLVERR;
   logic aclk = 0, aresetn = 0, ce = 1, go = 0, slow = 0, busy, irq;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, sel = 0;
   logic [63:0] periph_irq = 0;
   logic [3:0][15:0] dest_pointer;
   logic [3:0] pattern_match = 0, src_addr_bad = 0, dst_addr_bad = 0, xfer_step, chan_enable, chan_abort;
   logic [15:0] count = 0;
   int bad_count = 0, check_count = 0, cyc = 0;
   dcef_top dut (.*);
   dcef_eng_model eng (.*);
   initial forever #12.5 aclk = ~aclk;
   task automatic close_out();
      if (bad_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s: got %h want %h", $time, m, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er), "write resp");
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input string m);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed, m);
      chk(32'(s_axi_rresp), 32'(er), m);
   endtask
   function automatic logic [7:0] ra(input int c, input logic [4:0] o);
      return 8'(c * 32) + 8'(o);
   endfunction
   function automatic logic [31:0] exp_fl(input int n, input int cs, input int ss, input int ds);
      int mx;
      mx = ss > ds ? ss : ds;
      return {27'h0, n >= ds / 2, n >= mx, n >= cs, 2'b00};
   endfunction
   task automatic pulse(input int k, input int c);
      @(posedge aclk);
      case (k)
         0: src_addr_bad[c] <= 1'b1;
         1: dst_addr_bad[c] <= 1'b1;
         default: pattern_match[c] <= 1'b1;
      endcase
      @(posedge aclk);
      src_addr_bad <= 4'h0;
      dst_addr_bad <= 4'h0;
      pattern_match <= 4'h0;
      repeat (3) @(posedge aclk);
   endtask
   task automatic run(input int c, input int n);
      @(posedge aclk);
      sel <= 2'(c);
      count <= 16'(n);
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      do @(posedge aclk); while (busy);
      repeat (3) @(posedge aclk);
   endtask
   task automatic abort_cnt(input int c, input int line, output int n);
      @(posedge aclk);
      periph_irq[line] <= 1'b1;
      n = 0;
      repeat (6) begin
         @(posedge aclk);
         n += int'(chan_abort[c]);
      end
   endtask
   initial begin
      int cs, ss, ds, s, n, mx;
      n = $urandom(9);
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h80, 0, OK, "summary reset");
      rd(8'h18, 0, ER, "unmapped read");
      wr(8'h9c, 32'h1f, ER);
      for (int c = 0; c < 4; c++) begin
         rd(ra(c, 5'h00), 0, OK, "flags reset");
         rd(ra(c, 5'h08), 0, OK, "ctrl reset");
         wr(ra(c, 5'h04), 32'h1, OK);
         rd(ra(c, 5'h04), 32'h1, OK, "mask");
         pulse(c % 2, c);
         chk(32'(irq), 1, "irq on");
         rd(ra(c, 5'h00), 32'h1, OK, "addr err");
         chk(32'(irq), 0, "irq off");
         rd(ra(c, 5'h00), 0, OK, "read clears");
         wr(ra(c, 5'h04), 0, OK);
         pulse(1 - c % 2, c);
         chk(32'(irq), 0, "irq masked");
         rd(ra(c, 5'h00), 32'h1, OK, "masked err");
         pulse(2, c);
         rd(ra(c, 5'h00), 0, OK, "match off");
         cs = $urandom_range(5, 2);
         ss = $urandom_range(31, 16);
         ds = $urandom_range(40, 12);
         mx = ss > ds ? ss : ds;
         slow <= c[0];
         wr(ra(c, 5'h0c), 32'(ss), OK);
         wr(ra(c, 5'h10), 32'(ds), OK);
         wr(ra(c, 5'h14), 32'(cs), OK);
         wr(ra(c, 5'h08), 32'h1, OK);
         rd(8'h80, 32'h1 << (8 + c), OK, "summary enable");
         run(c, cs - 1);
         rd(ra(c, 5'h00), exp_fl(cs - 1, cs, ss, ds), OK, "partial");
         run(c, mx - cs + 1);
         rd(ra(c, 5'h00), exp_fl(mx, cs, ss, ds), OK, "block");
         pulse(2, c);
         rd(ra(c, 5'h00), 32'h8, OK, "match");
         s = $urandom_range(63, 0);
         wr(ra(c, 5'h08), 32'h3 | (32'(s) << 8), OK);
         abort_cnt(c, s ^ 1, n);
         chk(32'(n), 0, "wrong line");
         abort_cnt(c, s, n);
         chk(32'(n), 1, "abort pulse");
         chk(32'(chan_enable[c]), 0, "enable off");
         rd(ra(c, 5'h00), 32'h2, OK, "abort flag");
         periph_irq <= 64'h0;
      end
      close_out();
   end
endmodule
